// ==== rtl/ppb_boost_ctrl.v ====
// top of the pulse programmed boost converter control logic
`timescale 1ns/1ps
`include "ppb_regs.vh"
// How it works
// - main switch turns on when feedback below reference after min off
// - main switch turns off when current reaches the limit threshold
// - main switch forced off after six microseconds on
// - main switch stays off at least 400 ns and until feedback low
// - input disconnect switch is ramped on gradually at enable
// - soft start uses quarter, then half, then full current limit
// - rising program pin enables the device and starts soft start
// - pin low 560 us or longer shuts the device down
// - input disconnect switch stays open while shut down
// - output DAC code is six bits with 64 steps from zero
// - code zero gives 0 V, full scale gives the reference
// - every enable loads the DAC code with the center step
// - short low pulse steps code up, medium low pulse steps it down
// - without programming the pin acts as a plain enable
// - undervoltage holds both power switches open
// - overtemperature holds both power switches open
module ppb_boost_ctrl
(
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst_b,
  // enable and program pin
  input  wire       ctrl_pin,
  // analog comparator indications
  input  wire       feedback_input_low,
  input  wire       current_limit_hit,
  input  wire       undervoltage,
  input  wire       over_temp,
  // power switch gates
  output reg        input_disconnect_switch,
  output reg  [5:0] input_switch_ramp,
  output reg        main_power_switch,
  // current limit select and DAC code
  output reg  [1:0] switch_current_limit,
  output reg  [5:0] dac_code,
  // state
  output reg        device_enabled
);
  localparam [9:0]  MAX_ON   = `PPB_MAX_ON_CYC;
  localparam [9:0]  MIN_OFF  = `PPB_MIN_OFF_CYC;
  localparam [8:0]  SS_STAGE = `PPB_SS_STAGE_CYC;
  localparam [6:0]  RAMP_CYC = `PPB_RAMP_STEP_CYC;
  // last count of an on interval, of the minimum off time, of a ramp step
  localparam [9:0]  MAX_ON_END  = MAX_ON - 10'h001;
  localparam [9:0]  MIN_OFF_END = MIN_OFF - 10'h001;
  localparam [6:0]  RAMP_END    = RAMP_CYC - 7'h01;

  localparam [4:0] ST_OFF  = 5'h01;
  localparam [4:0] ST_RAMP = 5'h02;
  localparam [4:0] ST_SS1  = 5'h04;
  localparam [4:0] ST_SS2  = 5'h08;
  localparam [4:0] ST_RUN  = 5'h10;

  localparam [1:0] SW_OFF  = 2'h1;
  localparam [1:0] SW_ON   = 2'h2;

  wire pin_s;
  wire fb_s;
  wire switch_current_limit_s;
  wire uv_s;
  wire ot_s;
  wire step_up;
  wire step_down;
  wire long_low;
  wire pin_rise;

  reg [4:0] st_q;
  reg [1:0] sw_q;
  reg [9:0] sw_cnt_q;
  reg [8:0] ss_cnt_q;
  reg [6:0] ramp_cnt_q;

  ppb_sync2 #(.RESET_VAL(1'b0)) u_sync_pin
  (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in (ctrl_pin),
    .sync_out (pin_s)
  );
  ppb_sync2 #(.RESET_VAL(1'b0)) u_sync_fb
  (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in (feedback_input_low),
    .sync_out (fb_s)
  );
  ppb_sync2 #(.RESET_VAL(1'b0)) u_sync_switch_current_limit
  (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in (current_limit_hit),
    .sync_out (switch_current_limit_s)
  );
  // starts asserted so both switches stay open until the supply is known
  ppb_sync2 #(.RESET_VAL(1'b1)) u_sync_uv
  (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in (undervoltage),
    .sync_out (uv_s)
  );
  ppb_sync2 #(.RESET_VAL(1'b0)) u_sync_ot
  (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in (over_temp),
    .sync_out (ot_s)
  );

  ppb_pulse_meas u_meas
  (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .pin_level (pin_s),
    .step_up   (step_up),
    .step_down (step_down),
    .long_low  (long_low),
    .rise      (pin_rise)
  );

  // either fault opens both switches in the same cycle
  wire fault = uv_s || ot_s;
  // an on interval ends at peak current or at the on-time limit
  wire sw_end = (sw_q == SW_ON) &&
                (switch_current_limit_s || (sw_cnt_q == MAX_ON_END));

  // sequencer: enable, input switch ramp, soft start stages
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q       <= ST_OFF;
      ss_cnt_q   <= 9'h000;
      ramp_cnt_q <= 7'h00;
      input_switch_ramp <= 6'h00;
    end
    else if (fault)
    begin
      st_q              <= ST_OFF;
      input_switch_ramp <= 6'h00;
      ss_cnt_q          <= 9'h000;
      ramp_cnt_q        <= 7'h00;
    end
    else if (long_low)
    begin
      // a long low ends any stage, soft start included
      st_q              <= ST_OFF;
      input_switch_ramp <= 6'h00;
    end
    else
    begin
      case (st_q)
        ST_OFF:
        begin
          ss_cnt_q   <= 9'h000;
          ramp_cnt_q <= 7'h00;
          // plain level high enables, as a simple enable pin
          if (pin_rise || pin_s)
            st_q <= ST_RAMP;
        end
        ST_RAMP:
        begin
          ramp_cnt_q <= ramp_cnt_q + 7'h01;
          if (ramp_cnt_q == RAMP_END)
          begin
            ramp_cnt_q <= 7'h00;
            // gate drive rises one step at a time
            if (input_switch_ramp == `PPB_DAC_MAX)
              st_q <= ST_SS1;
            else
              input_switch_ramp <= input_switch_ramp + 6'h01;
          end
        end
        ST_SS1:
        begin
          if (sw_end)
          begin
            ss_cnt_q <= ss_cnt_q + 9'h001;
            if (ss_cnt_q == SS_STAGE - 9'h001)
            begin
              ss_cnt_q <= 9'h000;
              st_q     <= ST_SS2;
            end
          end
        end
        ST_SS2:
        begin
          if (sw_end)
          begin
            ss_cnt_q <= ss_cnt_q + 9'h001;
            if (ss_cnt_q == SS_STAGE - 9'h001)
            begin
              ss_cnt_q <= 9'h000;
              st_q     <= ST_RUN;
            end
          end
        end
        ST_RUN:
          // full limit holds until shutdown or a fault
          st_q <= ST_RUN;
        default:
          st_q <= ST_OFF;
      endcase
    end
  end

  wire switching = (st_q == ST_SS1) || (st_q == ST_SS2) || (st_q == ST_RUN);

  // pulse frequency loop for the main switch
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sw_q     <= SW_OFF;
      sw_cnt_q <= 10'h000;
    end
    else if (!switching || fault)
    begin
      sw_q     <= SW_OFF;
      sw_cnt_q <= 10'h000;
    end
    else
    begin
      case (sw_q)
        SW_OFF:
        begin
          if (sw_cnt_q < MIN_OFF)
            sw_cnt_q <= sw_cnt_q + 10'h001;
          if (sw_cnt_q >= MIN_OFF_END && fb_s)
          begin
            sw_q     <= SW_ON;
            sw_cnt_q <= 10'h000;
          end
        end
        SW_ON:
        begin
          sw_cnt_q <= sw_cnt_q + 10'h001;
          if (sw_end)
          begin
            // peak current or on-time limit
            sw_q     <= SW_OFF;
            sw_cnt_q <= 10'h000;
          end
        end
        default:
        begin
          sw_q     <= SW_OFF;
          sw_cnt_q <= 10'h000;
        end
      endcase
    end
  end

  // DAC code: centered at enable, stepped by program pulses
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      dac_code <= `PPB_DAC_CENTER;
    // steps seen while off are lost, the code is reloaded there
    else if (st_q == ST_OFF)
      dac_code <= `PPB_DAC_CENTER;
    else if (step_up && dac_code != `PPB_DAC_MAX)
      dac_code <= dac_code + 6'h01;
    else if (step_down && dac_code != 6'h00)
      dac_code <= dac_code - 6'h01;
  end

  // registered outputs
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      input_disconnect_switch <= 1'b0;
      main_power_switch       <= 1'b0;
      switch_current_limit    <= `PPB_SWITCH_CURRENT_LIMIT_NONE;
      device_enabled          <= 1'b0;
    end
    else
    begin
      // open while off or faulted
      input_disconnect_switch <= switching && !fault;
      // drops in the ending cycle so the gate never outlasts the limit
      main_power_switch       <= (sw_q == SW_ON) && switching && !fault &&
                                 !sw_end;
      device_enabled          <= (st_q != ST_OFF);
      case (st_q)
        ST_SS1:  switch_current_limit <= `PPB_SWITCH_CURRENT_LIMIT_QUARTER;
        ST_SS2:  switch_current_limit <= `PPB_SWITCH_CURRENT_LIMIT_HALF;
        ST_RUN:  switch_current_limit <= `PPB_SWITCH_CURRENT_LIMIT_FULL;
        default: switch_current_limit <= `PPB_SWITCH_CURRENT_LIMIT_NONE;
      endcase
    end
  end
endmodule

// ==== rtl/ppb_pulse_meas.v ====
// measures low pulses on the program pin and classifies them
`timescale 1ns/1ps
`include "ppb_regs.vh"
module ppb_pulse_meas
(
  // clock and reset
  input  wire ref_clk,
  input  wire rst_b,
  // synchronised pin level
  input  wire pin_level,
  // classified events, one-cycle pulses
  output reg  step_up,
  output reg  step_down,
  output reg  long_low,
  output reg  rise
);
  localparam [15:0] UP_MIN  = `PPB_UP_MIN_CYC;
  localparam [15:0] UP_MAX  = `PPB_UP_MAX_CYC;
  localparam [15:0] DN_MIN  = `PPB_DN_MIN_CYC;
  localparam [15:0] DN_MAX  = `PPB_DN_MAX_CYC;
  localparam [15:0] OFF_CYC = `PPB_OFF_CYC;

  reg        prev_q;
  reg [15:0] low_cnt_q;

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_q    <= 1'b0;
      low_cnt_q <= 16'h0000;
      step_up   <= 1'b0;
      step_down <= 1'b0;
      long_low  <= 1'b0;
      rise      <= 1'b0;
    end
    else
    begin
      prev_q    <= pin_level;
      step_up   <= 1'b0;
      step_down <= 1'b0;
      long_low  <= 1'b0;
      rise      <= pin_level && !prev_q;
      if (!pin_level)
      begin
        // count saturates just past the shutdown threshold
        if (low_cnt_q < OFF_CYC)
          low_cnt_q <= low_cnt_q + 16'h0001;
        if (low_cnt_q == OFF_CYC - 16'h0001)
          long_low <= 1'b1;
      end
      else
      begin
        low_cnt_q <= 16'h0000;
        if (!prev_q)
        begin
          // widths outside both windows are dropped
          if (low_cnt_q >= UP_MIN && low_cnt_q <= UP_MAX)
            step_up <= 1'b1;
          else if (low_cnt_q >= DN_MIN && low_cnt_q <= DN_MAX)
            step_down <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== rtl/ppb_regs.vh ====
// timing counts, codes and levels for the pulse programmed boost control
`ifndef PPB_REGS_VH
`define PPB_REGS_VH
`define PPB_CLK_MHZ        100
`define PPB_REF_MV         1233
`define PPB_SWITCH_CURRENT_LIMIT_MA        375
`define PPB_UVLO_MV        1500
`define PPB_TSD_DEGC       160
`define PPB_MAX_ON_US      6
`define PPB_MAX_ON_CYC     (`PPB_MAX_ON_US * `PPB_CLK_MHZ)
`define PPB_MIN_OFF_NS     400
`define PPB_MIN_OFF_CYC    ((`PPB_MIN_OFF_NS * `PPB_CLK_MHZ + 999) / 1000)
`define PPB_UP_MIN_US      1
`define PPB_UP_MAX_US      60
`define PPB_DN_MIN_US      140
`define PPB_DN_MAX_US      240
`define PPB_OFF_US         560
`define PPB_UP_MIN_CYC     (`PPB_UP_MIN_US * `PPB_CLK_MHZ)
`define PPB_UP_MAX_CYC     (`PPB_UP_MAX_US * `PPB_CLK_MHZ)
`define PPB_DN_MIN_CYC     (`PPB_DN_MIN_US * `PPB_CLK_MHZ)
`define PPB_DN_MAX_CYC     (`PPB_DN_MAX_US * `PPB_CLK_MHZ)
`define PPB_OFF_CYC        (`PPB_OFF_US * `PPB_CLK_MHZ)
`define PPB_SS_STAGE_CYC   256
`define PPB_RAMP_STEP_CYC  64
`define PPB_DAC_W          6
`define PPB_DAC_CENTER     6'h1f
`define PPB_DAC_MAX        6'h3f
`define PPB_SWITCH_CURRENT_LIMIT_QUARTER   2'h1
`define PPB_SWITCH_CURRENT_LIMIT_HALF      2'h2
`define PPB_SWITCH_CURRENT_LIMIT_FULL      2'h3
`define PPB_SWITCH_CURRENT_LIMIT_NONE      2'h0
`endif

// ==== rtl/ppb_sync2.v ====
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module ppb_sync2
#(
  parameter RESET_VAL = 1'b0
)
(
  // clock and reset
  input  wire ref_clk,
  input  wire rst_b,
  // level in and out
  input  wire async_in,
  output reg  sync_out
);
  reg meta_q;

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ==== verif/ppb_boost_ctrl_sva.sv ====
// assertion checker for the boost control top
`timescale 1ns/1ps
module ppb_boost_sva
(
  // clock and reset
  input wire       ref_clk,
  input wire       rst_b,
  // pin and comparator inputs
  input wire       ctrl_pin,
  input wire       feedback_input_low,
  input wire       current_limit_hit,
  input wire       undervoltage,
  input wire       over_temp,
  // switch and state outputs
  input wire       input_disconnect_switch,
  input wire [5:0] input_switch_ramp,
  input wire       main_power_switch,
  input wire [1:0] switch_current_limit,
  input wire [5:0] dac_code,
  input wire       device_enabled
);
  reg [9:0] on_cnt_q;
  reg [7:0] off_cnt_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // run lengths of the main switch on and off intervals
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      on_cnt_q  <= 10'h0;
      off_cnt_q <= 8'hff;
    end
    else
    begin
      on_cnt_q  <= main_power_switch ? on_cnt_q + 10'h1 : 10'h0;
      off_cnt_q <= main_power_switch ? 8'h0 :
                   (off_cnt_q == 8'hff ? off_cnt_q : off_cnt_q + 8'h1);
    end
  end
  fb_gate_a : assert property (
    !feedback_input_low [*6] |-> !$rose(main_power_switch))
    else $error("main switch closed with feedback high");
  switch_current_limit_stop_a : assert property (
    $rose(main_power_switch) ##1 current_limit_hit
    |-> ##[1:5] !main_power_switch)
    else $error("main switch stayed on past current limit");
  max_on_a : assert property (on_cnt_q <= 10'h258)
    else $error("main switch on interval too long");
  min_off_a : assert property (
    $rose(main_power_switch) |-> off_cnt_q >= 8'h28)
    else $error("main switch off interval too short");
  ramp_first_a : assert property (
    $rose(input_disconnect_switch) |-> $past(input_switch_ramp) == 6'h3f)
    else $error("input switch closed before ramp end");
  limit_order_a : assert property (
    $changed(switch_current_limit) && switch_current_limit != 2'h0
    |-> switch_current_limit == $past(switch_current_limit) + 2'h1)
    else $error("current limit stage out of order");
  shut_open_a : assert property (
    !device_enabled && $past(!device_enabled)
    |-> !input_disconnect_switch && !main_power_switch)
    else $error("switch closed while shut down");
  center_load_a : assert property (
    $rose(device_enabled) |-> dac_code == 6'h1f)
    else $error("enable without center code");
  code_step_a : assert property (
    $changed(dac_code) |-> dac_code == $past(dac_code) + 6'h1 ||
    dac_code == $past(dac_code) - 6'h1 || dac_code == 6'h1f)
    else $error("code moved by more than one step");
  uv_off_a : assert property (
    undervoltage [*6] |-> !input_disconnect_switch && !main_power_switch)
    else $error("switch closed under undervoltage");
  hot_off_a : assert property (
    over_temp [*6] |-> !input_disconnect_switch && !main_power_switch)
    else $error("switch closed while overheated");
  cover property (switch_current_limit == 2'h3);
  cover property (dac_code == 6'h3f);
  cover property ($fell(device_enabled));
  cover property ($fell(ctrl_pin) ##1 device_enabled);
endmodule
bind ppb_boost_ctrl ppb_boost_sva u_sva (
  .ref_clk(ref_clk), .rst_b(rst_b), .ctrl_pin(ctrl_pin),
  .feedback_input_low(feedback_input_low),
  .current_limit_hit(current_limit_hit),
  .undervoltage(undervoltage), .over_temp(over_temp),
  .input_disconnect_switch(input_disconnect_switch),
  .input_switch_ramp(input_switch_ramp),
  .main_power_switch(main_power_switch),
  .switch_current_limit(switch_current_limit),
  .dac_code(dac_code), .device_enabled(device_enabled));

// ==== verif/ppb_host_model.sv ====
// host controller model driving the enable and program pin
`timescale 1ns/1ps
module ppb_host_model
(
  // clock
  input wire ref_clk,
  // driven pin
  output reg ctrl_pin
);
  // pin is always driven, low until the host enables
  initial ctrl_pin = 1'b0;
  // low pulse of n cycles, then a high gap before anything else
  task low_pulse(input integer n);
  begin
    @(posedge ref_clk);
    ctrl_pin <= 1'b0;
    repeat (n) @(posedge ref_clk);
    ctrl_pin <= 1'b1;
    repeat (110) @(posedge ref_clk);
  end
  endtask
  task set_level(input reg v);
  begin
    @(posedge ref_clk);
    ctrl_pin <= v;
  end
  endtask
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the boost control top
`timescale 1ns/1ps
module tb_top;
  reg        ref_clk;
  reg        rst_b;
  reg        feedback_input_low;
  reg        current_limit_hit;
  reg        undervoltage;
  reg        over_temp;
  reg        switch_current_limit_en;
  wire       ctrl_pin;
  wire       input_disconnect_switch;
  wire [5:0] input_switch_ramp;
  wire       main_power_switch;
  wire [1:0] switch_current_limit;
  wire [5:0] dac_code;
  wire       device_enabled;
  integer    failures;
  integer    checks;
  integer    cycles;
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  ppb_host_model host (.ref_clk(ref_clk), .ctrl_pin(ctrl_pin));
  ppb_boost_ctrl dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .ctrl_pin(ctrl_pin),
    .feedback_input_low(feedback_input_low),
    .current_limit_hit(current_limit_hit),
    .undervoltage(undervoltage), .over_temp(over_temp),
    .input_disconnect_switch(input_disconnect_switch),
    .input_switch_ramp(input_switch_ramp),
    .main_power_switch(main_power_switch),
    .switch_current_limit(switch_current_limit),
    .dac_code(dac_code), .device_enabled(device_enabled));
  // inductor current reaches the limit a cycle after the switch closes
  always @(posedge ref_clk)
    current_limit_hit <= switch_current_limit_en & main_power_switch;
  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 112000)
    begin
      failures = failures + 1;
      complete_run;
    end
  end
  task complete_run;
  begin
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task do_reset;
  begin
    rst_b <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
  end
  endtask
  // counts main switch closures while one limit stage lasts
  task count_stage(input [1:0] lim, output integer n);
    reg m;
  begin
    n = 0;
    m = main_power_switch;
    while (switch_current_limit === lim)
    begin
      @(negedge ref_clk);
      n = n + (main_power_switch & ~m);
      m = main_power_switch;
    end
  end
  endtask
  task t_soft_start;
    integer n;
  begin
    feedback_input_low <= 1'b1;
    host.set_level(1'b1);
    while (input_disconnect_switch !== 1'b1) @(negedge ref_clk);
    chk(dac_code, 16'h1f);
    chk(switch_current_limit, 16'h1);
    chk(input_switch_ramp, 16'h3f);
    count_stage(2'h1, n);
    chk(n, 16'h100);
    count_stage(2'h2, n);
    chk(n, 16'h100);
    chk(switch_current_limit, 16'h3);
  end
  endtask
  task t_max_on;
    integer n;
  begin
    @(posedge ref_clk);
    switch_current_limit_en <= 1'b0;
    while (main_power_switch !== 1'b1) @(negedge ref_clk);
    n = 0;
    while (main_power_switch === 1'b1)
    begin
      @(negedge ref_clk);
      n = n + 1;
    end
    // the gate drops in the edge that ends the 600 cycle interval
    chk(n, 16'h257);
    switch_current_limit_en <= 1'b1;
  end
  endtask
  // feedback above the reference keeps the main switch open
  task t_fb;
    integer n;
  begin
    @(posedge ref_clk);
    feedback_input_low <= 1'b0;
    repeat (8) @(posedge ref_clk);
    n = 0;
    repeat (200)
    begin
      @(negedge ref_clk);
      n = n + main_power_switch;
    end
    chk(n, 16'h0);
    @(posedge ref_clk);
    feedback_input_low <= 1'b1;
    n = 0;
    while (main_power_switch !== 1'b1)
    begin
      @(negedge ref_clk);
      n = n + 1;
    end
    // two sync stages, one state edge, one output edge
    chk(n, 16'h5);
    while (main_power_switch === 1'b1) @(negedge ref_clk);
    n = 0;
    while (main_power_switch !== 1'b1)
    begin
      @(negedge ref_clk);
      n = n + 1;
    end
    // 40 cycles off state plus the output lag of one cycle
    chk(n, 16'h29);
  end
  endtask
  task t_steps;
    integer i;
    reg [5:0] e;
  begin
    e = 6'h1f;
    for (i = 0; i < 33; i = i + 1)
    begin
      host.low_pulse(150);
      if (e != 6'h3f)
        e = e + 6'h1;
      chk(dac_code, e);
    end
    host.low_pulse(50);
    chk(dac_code, e);
    host.low_pulse(14400);
    chk(dac_code, 16'h3e);
  end
  endtask
  task t_fault(input reg hot);
  begin
    @(posedge ref_clk);
    over_temp <= hot;
    undervoltage <= !hot;
    repeat (8) @(negedge ref_clk);
    chk(device_enabled, 16'h0);
    chk(input_disconnect_switch, 16'h0);
    chk(main_power_switch, 16'h0);
    chk(dac_code, 16'h1f);
    @(posedge ref_clk);
    over_temp <= 1'b0;
    undervoltage <= 1'b0;
  end
  endtask
  task t_shutdown;
  begin
    while (device_enabled !== 1'b1) @(negedge ref_clk);
    chk(dac_code, 16'h1f);
    host.set_level(1'b0);
    repeat (55900) @(negedge ref_clk);
    chk(device_enabled, 16'h1);
    repeat (200) @(negedge ref_clk);
    chk(device_enabled, 16'h0);
    chk(input_disconnect_switch, 16'h0);
    host.set_level(1'b1);
    while (device_enabled !== 1'b1) @(negedge ref_clk);
    chk(dac_code, 16'h1f);
  end
  endtask
  initial
  begin
    rst_b = 1'b0;
    feedback_input_low = 1'b0;
    current_limit_hit = 1'b0;
    undervoltage = 1'b0;
    over_temp = 1'b0;
    switch_current_limit_en = 1'b1;
    failures = 0;
    checks = 0;
    cycles = 0;
    do_reset;
    t_soft_start;
    t_max_on;
    t_fb;
    t_steps;
    t_fault(1'b1);
    do_reset;
    t_shutdown;
    t_fault(1'b0);
    complete_run;
  end
endmodule
